/* File: src/ttsl_pkg.sv */
// Contract
// - Reset leaves comparator mode, active-low alarm and one-fault tolerance: all config bits zero.
// - Reset loads upper trip point with 80 degC and lower with 75 degC.
// - Reset sets the register pointer to zero, selecting temperature.
// - Device is slave only and never drives the clock line.
// - Each frame is eight data clocks plus one acknowledge clock.
// - Address byte matches prefix 1001 plus three pins; bit 0 is direction.
// - Data changes only while clock is low; changes while high are conditions.
// - Falling data while clock is high is a START.
// - Rising data while clock is high is a STOP.
// - No limit on the number of bytes between START and STOP.
// - Acknowledger holds data low through the whole ninth clock high phase.
// - Device acknowledges address, pointer and every written data byte.
// - Master NACK ends a read; device releases data for the STOP.
// - First byte after acknowledged write address loads the register pointer.
// - Reads use the held pointer or a fresh pointer write; pointer persists.
// - Temperature and trip point reads return two bytes, high byte first.
// - Configuration read returns a single byte.
// - In a write, bytes after the pointer go into the selected register; bytes written with the temperature pointer are discarded.
// - Pointer value 3 selects the 16-bit read/write upper trip point.
// - Config byte: bit0 power down, bit1 mode, bit2 polarity, bits4:3 faults, 7:5 zero.
// - A new temperature result is held off while a read is in progress.
package ttsl_pkg;
  localparam logic [3:0] ADDR_PREFIX = 4'h9;
  localparam logic [1:0] PTR_TEMP = 2'h0;
  localparam logic [1:0] PTR_CONF = 2'h1;
  localparam logic [1:0] PTR_LOWER = 2'h2;
  localparam logic [1:0] PTR_UPPER = 2'h3;
  localparam logic [1:0] PTR_RESET = 2'h0;
  localparam logic [4:0] CONF_RESET = 5'h00;
  localparam logic [15:0] UPPER_RESET = 16'h5000;
  localparam logic [15:0] LOWER_RESET = 16'h4B00;
  localparam logic [15:0] TEMP_RESET = 16'h0000;
  localparam int CONF_PWRDN_BIT = 0;
  localparam int CONF_MODE_BIT = 1;
  localparam int CONF_POL_BIT = 2;
  localparam int CONF_FT_LO_BIT = 3;
  localparam int CONF_FT_HI_BIT = 4;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  typedef enum logic [2:0] {
    S_IDLE,
    S_ADDR,
    S_ADDR_ACK,
    S_RX,
    S_RX_ACK,
    S_TX,
    S_TX_ACK
  } ttsl_state_e;
endpackage

/* File: src/ttsl_cond_if.sv */
`timescale 1ns/10ps
interface ttsl_cond_if;
  logic scl_level;
  logic sda_level;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  modport source (output scl_level, sda_level, scl_rise, scl_fall, start_seen, stop_seen);
  modport sink (input scl_level, sda_level, scl_rise, scl_fall, start_seen, stop_seen);
endinterface

/* File: src/ttsl_bus_cond.sv */
`timescale 1ns/10ps
module ttsl_bus_cond (
  input wire logic sys_clk_i, // System clock.
  input wire logic sys_rst_i, // Synchronous reset, active high.
  input wire logic scl_i, // Bus clock line from the pin.
  input wire logic sda_i, // Bus data line from the pin.
  ttsl_cond_if.source cond // Decoded bus events.
);
  logic scl_m;
  logic scl_s;
  logic scl_p;
  logic sda_m;
  logic sda_s;
  logic sda_p;

  // Two-stage synchronisers; the third stage only feeds edge detection.
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_p <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_p <= 1'b1;
    end else begin
      scl_m <= scl_i;
      scl_s <= scl_m;
      scl_p <= scl_s;
      sda_m <= sda_i;
      sda_s <= sda_m;
      sda_p <= sda_s;
    end
  end

  assign cond.scl_level = scl_s;
  assign cond.sda_level = sda_s;
  assign cond.scl_rise = scl_s & ~scl_p;
  assign cond.scl_fall = ~scl_s & scl_p;
  assign cond.start_seen = scl_s & scl_p & sda_p & ~sda_s;
  assign cond.stop_seen = scl_s & scl_p & ~sda_p & sda_s;
endmodule

/* File: src/ttsl_top.sv */
`timescale 1ns/10ps
module ttsl_top
  import ttsl_pkg::*;
(
  input wire logic sys_clk_i, // System clock, 250 MHz.
  input wire logic sys_rst_i, // Synchronous reset, active high.
  input wire logic scl_i, // Bus clock pin, driven by the master only.
  input wire logic sda_i, // Bus data pin level.
  output logic sda_o, // Data pin output value, always low.
  output logic sda_oe_n_o, // Data pin enable, low while pulling low.
  input wire logic addr_select_pin_hi_i, // Address select pin, address bit 3.
  input wire logic addr_select_pin_mid_i, // Address select pin, address bit 2.
  input wire logic addr_select_pin_lo_i, // Address select pin, address bit 1.
  input wire logic [15:0] temp_value_i, // New conversion result.
  input wire logic temp_valid_i, // Pulse: conversion result ready.
  output logic power_down_ctrl_o, // Config power down control.
  output logic thermostat_mode_o, // Config mode, 0 comparator, 1 interrupt.
  output logic alarm_polarity_o, // Config alarm polarity.
  output logic fault_count_select_hi_o, // Config fault tolerance high bit.
  output logic fault_count_select_lo_o, // Config fault tolerance low bit.
  output logic [15:0] upper_trip_point_o, // Upper trip point register.
  output logic [15:0] lower_trip_point_o, // Lower trip point register.
  output logic [15:0] temp_reg_o, // Temperature register as seen by reads.
  output logic busy_o // A transfer is in progress: high from START until STOP, a read NACK or a foreign address.
);
  ttsl_cond_if cond ();

  ttsl_bus_cond u_cond (
    .sys_clk_i (sys_clk_i),
    .sys_rst_i (sys_rst_i),
    .scl_i (scl_i),
    .sda_i (sda_i),
    .cond (cond.source)
  );

  ttsl_state_e state;
  logic [3:0] bit_cnt;
  logic [7:0] shift;
  logic rw;
  logic first_rx;
  logic byte_sel;
  logic [1:0] ptr;
  logic [4:0] conf;
  logic [15:0] upper;
  logic [15:0] lower;
  logic [15:0] temp_reg;
  logic [15:0] temp_pend;
  logic pend_valid;
  logic sda_oe_n;
  logic [2:0] pins_m;
  logic [2:0] pins_s;

  wire byte_done = (bit_cnt == BITS_PER_BYTE);
  wire [7:0] next_shift = {shift[6:0], cond.sda_level};
  wire addr_match = (shift[7:4] == ADDR_PREFIX) && (shift[3:1] == pins_s);
  wire is_word = (ptr != PTR_CONF);
  wire [15:0] word_sel = (ptr == PTR_TEMP) ? temp_reg :
                         (ptr == PTR_LOWER) ? lower : upper;
  wire [7:0] word_byte = byte_sel ? word_sel[7:0] : word_sel[15:8];
  wire [7:0] tx_byte = is_word ? word_byte : {3'h0, conf};
  wire rx_commit = (state == S_RX) && cond.scl_fall && byte_done;
  // The read is in progress from its acknowledged address on, so both bytes come from one result.
  wire reading = (state == S_TX) || (state == S_TX_ACK) || (state == S_ADDR_ACK && rw);

  // Address pins are straps from outside this clock domain.
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      pins_m <= 3'h0;
      pins_s <= 3'h0;
    end else begin
      pins_m <= {addr_select_pin_hi_i, addr_select_pin_mid_i, addr_select_pin_lo_i};
      pins_s <= pins_m;
    end
  end

  // Protocol engine: samples on clock rise, changes data on clock fall.
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      state <= S_IDLE;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      rw <= 1'b0;
      first_rx <= 1'b0;
      byte_sel <= 1'b0;
      sda_oe_n <= 1'b1;
    end else if (cond.start_seen) begin
      state <= S_ADDR;
      bit_cnt <= 4'h0;
      sda_oe_n <= 1'b1;
    end else if (cond.stop_seen) begin
      state <= S_IDLE;
      sda_oe_n <= 1'b1;
    end else begin
      unique case (state)
        S_IDLE: begin
          sda_oe_n <= 1'b1;
        end
        S_ADDR: begin
          if (cond.scl_rise) begin
            shift <= next_shift;
            bit_cnt <= bit_cnt + 4'h1;
          end else if (cond.scl_fall && byte_done) begin
            if (addr_match) begin
              sda_oe_n <= 1'b0;
              state <= S_ADDR_ACK;
              rw <= shift[0];
              byte_sel <= 1'b0;
              first_rx <= 1'b1;
              bit_cnt <= 4'h0;
            end else begin
              state <= S_IDLE;
            end
          end
        end
        S_ADDR_ACK: begin
          if (cond.scl_fall) begin
            bit_cnt <= 4'h0;
            if (rw) begin
              state <= S_TX;
              shift <= tx_byte;
              sda_oe_n <= tx_byte[7];
            end else begin
              state <= S_RX;
              sda_oe_n <= 1'b1;
            end
          end
        end
        S_RX: begin
          if (cond.scl_rise) begin
            shift <= next_shift;
            bit_cnt <= bit_cnt + 4'h1;
          end else if (rx_commit) begin
            sda_oe_n <= 1'b0;
            state <= S_RX_ACK;
            bit_cnt <= 4'h0;
            first_rx <= 1'b0;
            if (!first_rx) begin
              byte_sel <= ~byte_sel;
            end
          end
        end
        S_RX_ACK: begin
          if (cond.scl_fall) begin
            sda_oe_n <= 1'b1;
            state <= S_RX;
          end
        end
        S_TX: begin
          if (cond.scl_rise) begin
            bit_cnt <= bit_cnt + 4'h1;
          end else if (cond.scl_fall) begin
            if (byte_done) begin
              sda_oe_n <= 1'b1;
              state <= S_TX_ACK;
              byte_sel <= is_word ? ~byte_sel : 1'b0;
            end else begin
              sda_oe_n <= shift[6];
              shift <= {shift[6:0], 1'b1};
            end
          end
        end
        S_TX_ACK: begin
          if (cond.scl_rise && cond.sda_level) begin
            state <= S_IDLE;
          end else if (cond.scl_fall) begin
            state <= S_TX;
            shift <= tx_byte;
            sda_oe_n <= tx_byte[7];
            bit_cnt <= 4'h0;
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // Register writes from the bus; the first byte of a write is the pointer.
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      ptr <= PTR_RESET;
      conf <= CONF_RESET;
      upper <= UPPER_RESET;
      lower <= LOWER_RESET;
    end else if (rx_commit) begin
      if (first_rx) begin
        ptr <= shift[1:0];
      end else begin
        unique case (ptr)
          PTR_CONF: conf <= shift[4:0];
          PTR_LOWER: begin
            if (byte_sel) lower[7:0] <= shift;
            else lower[15:8] <= shift;
          end
          PTR_UPPER: begin
            if (byte_sel) upper[7:0] <= shift;
            else upper[15:8] <= shift;
          end
          PTR_TEMP: begin
          end
        endcase
      end
    end
  end

  // A result that lands during a read waits until the read is over.
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      temp_reg <= TEMP_RESET;
      temp_pend <= TEMP_RESET;
      pend_valid <= 1'b0;
    end else if (temp_valid_i && reading) begin
      temp_pend <= temp_value_i;
      pend_valid <= 1'b1;
    end else if (temp_valid_i) begin
      temp_reg <= temp_value_i;
      pend_valid <= 1'b0;
    end else if (pend_valid && !reading) begin
      temp_reg <= temp_pend;
      pend_valid <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      sda_o <= 1'b0;
      sda_oe_n_o <= 1'b1;
      busy_o <= 1'b0;
      power_down_ctrl_o <= CONF_RESET[CONF_PWRDN_BIT];
      thermostat_mode_o <= CONF_RESET[CONF_MODE_BIT];
      alarm_polarity_o <= CONF_RESET[CONF_POL_BIT];
      fault_count_select_hi_o <= CONF_RESET[CONF_FT_HI_BIT];
      fault_count_select_lo_o <= CONF_RESET[CONF_FT_LO_BIT];
      upper_trip_point_o <= UPPER_RESET;
      lower_trip_point_o <= LOWER_RESET;
      temp_reg_o <= TEMP_RESET;
    end else begin
      sda_o <= 1'b0;
      sda_oe_n_o <= sda_oe_n;
      busy_o <= (state != S_IDLE);
      power_down_ctrl_o <= conf[CONF_PWRDN_BIT];
      thermostat_mode_o <= conf[CONF_MODE_BIT];
      alarm_polarity_o <= conf[CONF_POL_BIT];
      fault_count_select_hi_o <= conf[CONF_FT_HI_BIT];
      fault_count_select_lo_o <= conf[CONF_FT_LO_BIT];
      upper_trip_point_o <= upper;
      lower_trip_point_o <= lower;
      temp_reg_o <= temp_reg;
    end
  end

  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);

  conf_reset_a: assert property ($fell(sys_rst_i) |-> conf == 5'h00 && ptr == 2'h0)
    else $error("config or pointer not cleared by reset");
  trip_reset_a: assert property ($fell(sys_rst_i) |-> upper == 16'h5000 && lower == 16'h4B00)
    else $error("trip points not at reset values");
  no_high_drive_a: assert property (sda_o == 1'b0)
    else $error("data pin output driven high");
  start_enters_a: assert property (cond.start_seen |=> state == S_ADDR && sda_oe_n)
    else $error("START not taken");
  stop_leaves_a: assert property (cond.stop_seen |=> state == S_IDLE ##1 sda_oe_n_o)
    else $error("STOP did not release the bus");
  addr_ack_a: assert property (state == S_ADDR && cond.scl_fall && byte_done && addr_match
    |=> !sda_oe_n ##1 !sda_oe_n_o)
    else $error("matching address not acknowledged");
  addr_miss_a: assert property (state == S_ADDR && cond.scl_fall && byte_done && !addr_match
    |=> state == S_IDLE && sda_oe_n)
    else $error("foreign address acknowledged");
  ptr_load_a: assert property (rx_commit && first_rx |=> ptr == $past(shift[1:0]))
    else $error("pointer not loaded from first write byte");
  temp_hold_a: assert property (reading && temp_valid_i |=> temp_reg == $past(temp_reg))
    else $error("temperature changed during a read");
  sda_change_a: assert property (!$stable(sda_oe_n) && !$past(sys_rst_i)
    |-> $past(cond.scl_fall || cond.start_seen || cond.stop_seen || state == S_IDLE))
    else $error("data changed outside clock low phase");
  nack_end_a: assert property (state == S_TX_ACK && cond.scl_rise && cond.sda_level
    && !cond.stop_seen && !cond.start_seen |=> state == S_IDLE && sda_oe_n)
    else $error("NACK did not end the read");
  rx_ack_a: assert property (rx_commit |=> !sda_oe_n && state == S_RX_ACK)
    else $error("received byte not acknowledged");
  ack_hold_a: assert property (state == S_RX_ACK && !cond.scl_fall && !cond.start_seen && !cond.stop_seen
    |=> !sda_oe_n)
    else $error("acknowledge released before the clock fell");
  tx_release_a: assert property (state == S_TX && cond.scl_fall && byte_done
    |=> sda_oe_n && state == S_TX_ACK)
    else $error("data line not released for the master acknowledge");
  word_order_a: assert property (state == S_ADDR_ACK && cond.scl_fall && rw && is_word
    |=> shift == $past(word_sel[15:8]))
    else $error("word read did not start with the high byte");
endmodule

/* File: tb/ttsl_master.sv */
`timescale 1ns/10ps
module ttsl_master #(
  parameter time QTR = 12ns
) (
  input wire logic clk_i, // System clock, only to keep bus edges off its sampling edge.
  input wire logic sda_i, // Resolved data wire.
  output logic scl_o, // Bus clock, driven by the master alone.
  output logic sda_o // Data drive, 1 releases to the pull-up.
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  // Works from idle and, as a repeated start, from clock low.
  task automatic start_cond();
    @(posedge clk_i);
    #1;
    sda_o = 1'b1;
    #QTR scl_o = 1'b1;
    #QTR sda_o = 1'b0;
    #QTR scl_o = 1'b0;
    #QTR;
  endtask

  task automatic stop_cond();
    @(posedge clk_i);
    #1;
    sda_o = 1'b0;
    #QTR scl_o = 1'b1;
    #QTR sda_o = 1'b1;
    #QTR;
  endtask

  // Data moves only in the low phase and is sampled mid-high.
  task automatic xfer_bit(input logic b, output logic r);
    sda_o = b;
    #QTR scl_o = 1'b1;
    #QTR r = sda_i;
    #QTR scl_o = 1'b0;
    #QTR;
  endtask

  task automatic wr_byte(input logic [7:0] d, output logic ack_n);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xfer_bit(d[i], r);
    end
    xfer_bit(1'b1, ack_n);
  endtask

  task automatic rd_byte(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xfer_bit(1'b1, r);
      d[i] = r;
    end
    xfer_bit(nack, r);
  endtask
endmodule

/* File: tb/ttsl_top_tb.sv */
`timescale 1ns/10ps
module ttsl_top_tb;
  import ttsl_pkg::*;
  localparam int TIMEOUT_CYCLES = 40000;
  localparam logic [7:0] ADDR_W = 8'h9A;
  localparam logic [7:0] ADDR_R = 8'h9B;
  logic sys_clk, sys_rst, scl, sda_m, sda_out, sda_oe_n, busy, temp_valid;
  logic pwrdn, mode, alarm_polarity, ft_hi, ft_lo;
  logic [2:0] pins;
  logic [15:0] temp_value, upper, lower, temp_reg;
  wire logic sda = sda_m & (sda_oe_n | sda_out);
  wire logic [15:0] conf_bits = {11'h000, ft_hi, ft_lo, alarm_polarity, mode, pwrdn};
  int fail_count = 0;
  int checked = 0;
  int cycles = 0;

  ttsl_top i_dut (.sys_clk_i(sys_clk), .sys_rst_i(sys_rst), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_out), .sda_oe_n_o(sda_oe_n), .addr_select_pin_hi_i(pins[2]),
    .addr_select_pin_mid_i(pins[1]), .addr_select_pin_lo_i(pins[0]), .temp_value_i(temp_value),
    .temp_valid_i(temp_valid), .power_down_ctrl_o(pwrdn), .thermostat_mode_o(mode),
    .alarm_polarity_o(alarm_polarity), .fault_count_select_hi_o(ft_hi), .fault_count_select_lo_o(ft_lo),
    .upper_trip_point_o(upper), .lower_trip_point_o(lower), .temp_reg_o(temp_reg), .busy_o(busy));

  ttsl_master i_master (.clk_i(sys_clk), .sda_i(sda), .scl_o(scl), .sda_o(sda_m));

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == TIMEOUT_CYCLES) begin
      fail_count++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic send(input logic [7:0] d);
    logic a;
    i_master.wr_byte(d, a);
    chk({15'h0000, a}, 16'h0000);
  endtask

  task automatic recv(input logic nack, input logic [7:0] exp);
    logic [7:0] d;
    i_master.rd_byte(nack, d);
    chk({8'h00, d}, {8'h00, exp});
  endtask

  task automatic pulse_temp(input logic [15:0] v);
    @(posedge sys_clk);
    #1;
    temp_value = v;
    temp_valid = 1'b1;
    @(posedge sys_clk);
    #1;
    temp_valid = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask

  task automatic test_reset();
    chk(conf_bits, 16'h0000);
    chk(upper, 16'h5000);
    chk(lower, 16'h4B00);
    pulse_temp(16'h1A80);
    i_master.start_cond();
    send(ADDR_R);
    recv(1'b0, 8'h1A);
    recv(1'b1, 8'h80);
    chk({15'h0000, sda_oe_n}, 16'h0001);
    i_master.stop_cond();
    repeat (8) @(posedge sys_clk);
    #1;
    chk({15'h0000, busy}, 16'h0000);
    $display("test_reset done");
  endtask

  task automatic test_upper();
    i_master.start_cond();
    send(ADDR_W);
    send(8'h03);
    send(8'h12);
    send(8'h34);
    send(8'h56);
    send(8'h78);
    chk(upper, 16'h5678);
    i_master.start_cond();
    send(ADDR_R);
    recv(1'b0, 8'h56);
    recv(1'b1, 8'h78);
    i_master.stop_cond();
    i_master.start_cond();
    send(ADDR_R);
    recv(1'b0, 8'h56);
    recv(1'b1, 8'h78);
    i_master.stop_cond();
    $display("test_upper done");
  endtask

  task automatic test_conf_lower();
    i_master.start_cond();
    send(ADDR_W);
    send(8'h01);
    send(8'hFF);
    chk(conf_bits, 16'h001F);
    i_master.start_cond();
    send(ADDR_R);
    recv(1'b1, 8'h1F);
    i_master.stop_cond();
    i_master.start_cond();
    send(ADDR_W);
    send(8'h02);
    send(8'h56);
    send(8'h80);
    i_master.stop_cond();
    chk(lower, 16'h5680);
    $display("test_conf_lower done");
  endtask

  task automatic test_wrong_addr();
    logic [7:0] bad [2] = '{8'h9C, 8'h1A};
    logic a;
    foreach (bad[i]) begin
      i_master.start_cond();
      i_master.wr_byte(bad[i], a);
      chk({15'h0000, a}, 16'h0001);
      i_master.wr_byte(8'h00, a);
      chk({15'h0000, a}, 16'h0001);
      chk({15'h0000, busy}, 16'h0000);
      i_master.stop_cond();
    end
    chk(conf_bits, 16'h001F);
    // Moving the straps moves the address; the held pointer still selects the lower trip point.
    pins = 3'h6;
    repeat (4) @(posedge sys_clk);
    i_master.start_cond();
    send(8'h9D);
    recv(1'b1, 8'h56);
    i_master.stop_cond();
    pins = 3'h5;
    $display("test_wrong_addr done");
  endtask

  task automatic test_temp_hold();
    i_master.start_cond();
    send(ADDR_W);
    send(8'h00);
    i_master.start_cond();
    send(ADDR_R);
    recv(1'b0, 8'h1A);
    // The result lands while the low byte is clocked, with no gap in the bus clock.
    fork
      recv(1'b1, 8'h80);
      begin
        pulse_temp(16'h2B00);
        chk(temp_reg, 16'h1A80);
      end
    join
    i_master.stop_cond();
    repeat (4) @(posedge sys_clk);
    #1;
    chk(temp_reg, 16'h2B00);
    $display("test_temp_hold done");
  endtask

  initial begin
    sys_rst = 1'b1;
    pins = 3'h5;
    temp_value = 16'h0000;
    temp_valid = 1'b0;
    repeat (12) @(posedge sys_clk);
    #1;
    sys_rst = 1'b0;
    repeat (4) @(posedge sys_clk);
    #1;
    test_reset();
    test_upper();
    test_conf_lower();
    test_wrong_addr();
    test_temp_hold();
    tally_and_finish();
  end
endmodule
